//--- rtl/hw_consts.svh
// constants of the harvard core datapath: map, field positions, reset values
// Notes on behaviour
// - every instruction is one 12-bit word
// - one whole instruction fetched per cycle
// - next fetch overlaps current execute
// - one cycle each, flow changes take two
// - program space 512, 1K or 2K words
// - separate buses, 8-bit data, 12-bit code
// - core registers mapped, direct or indirect reach
// - any operation on any register, any mode
// - 8-bit add, subtract, shift, logic unit
// - arithmetic is two's complement
// - two operands: working register plus file/literal
// - one operand: working register or file
// - 8-bit accumulator, not in data map
// - carry, nibble carry, zero updated per op
// - subtraction: carries mean no borrow
`ifndef HW_CONSTS_SVH
`define HW_CONSTS_SVH
`define HW_INSTR_W 12
`define HW_DATA_W 8
`define HW_FILE_AW 5
`define HW_PC_W_DEF 11
`define HW_PC_W_MIN 9
`define HW_PC_W_MAX 11
`define HW_ADDR_INDIRECT 5'h00
`define HW_ADDR_PCL 5'h02
`define HW_ADDR_STATUS 5'h03
`define HW_ADDR_FSR 5'h04
`define HW_BIT_C 0
`define HW_BIT_NIBBLE 1
`define HW_BIT_Z 2
`define HW_STATUS_RST 8'h00
`define HW_FSR_RST 8'h00
`define HW_W_RST 8'h00
`define HW_RESET_VEC 11'h000
`endif

//--- rtl/hw_pkg.sv
// types shared by the harvard core datapath
package hw_pkg;
    typedef enum logic [1:0] {
        CLS_FILE = 2'b00,
        CLS_RSVD = 2'b01,
        CLS_GOTO = 2'b10,
        CLS_LIT  = 2'b11
    } hw_class_type;

    // file-op field of the instruction is the unit operation itself
    typedef enum logic [3:0] {
        ALU_NOP  = 4'h0,
        ALU_MOVW = 4'h1,
        ALU_CLR  = 4'h2,
        ALU_SUB  = 4'h3,
        ALU_DEC  = 4'h4,
        ALU_IOR  = 4'h5,
        ALU_AND  = 4'h6,
        ALU_XOR  = 4'h7,
        ALU_ADD  = 4'h8,
        ALU_MOVB = 4'h9,
        ALU_COM  = 4'ha,
        ALU_INC  = 4'hb,
        ALU_RR   = 4'hc,
        ALU_RL   = 4'hd,
        ALU_SWAP = 4'he,
        ALU_RSVD = 4'hf
    } hw_alu_op_type;

    typedef struct packed {
        logic z;
        logic nibble_carry_flag;
        logic c;
    } hw_flags_type;

    typedef struct packed {
        logic [7:0] result;
        hw_flags_type flags;
        hw_flags_type affect;
    } hw_alu_out_type;

    typedef struct packed {
        logic we;
        logic [4:0] addr;
        logic [7:0] data;
    } hw_file_wr_type;
endpackage : hw_pkg

//--- rtl/hw_alu.sv
// 8-bit arithmetic and logic unit of the harvard core
`include "hw_consts.svh"
module hw_alu (
    input hw_pkg::hw_alu_op_type OP,
    input logic [7:0] W_IN,
    input logic [7:0] B_IN,
    input logic CARRY_IN,
    output hw_pkg::hw_alu_out_type RES
);
    import hw_pkg::*;

    // returns {carry, nibble carry, sum}
    function automatic logic [9:0] add_nib(input logic [7:0] x, input logic [7:0] y, input logic ci);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
        hi = {1'b0, x[7:4]} + {1'b0, y[7:4]} + {4'h0, lo[4]};
        return {hi[4], lo[4], hi[3:0], lo[3:0]};
    endfunction : add_nib

    wire [9:0] sum_add = add_nib(B_IN, W_IN, 1'b0);
    wire [9:0] sum_sub = add_nib(B_IN, ~W_IN, 1'b1);
    wire [9:0] sum_inc = add_nib(B_IN, 8'h01, 1'b0);
    wire [9:0] sum_dec = add_nib(B_IN, 8'hff, 1'b0);

    logic [7:0] res;
    logic c_out;
    logic nib_out;
    hw_flags_type aff;

    always_comb begin
        res = B_IN;
        c_out = CARRY_IN;
        nib_out = 1'b0;
        aff = '{z: 1'b1, nibble_carry_flag: 1'b0, c: 1'b0};
        case (OP)
            ALU_NOP, ALU_MOVW: begin
                res = W_IN;
                aff = '0;
            end
            ALU_CLR: res = 8'h00;
            ALU_SUB: begin
                {c_out, nib_out, res} = sum_sub;
                aff = '1;
            end
            ALU_ADD: begin
                {c_out, nib_out, res} = sum_add;
                aff = '1;
            end
            ALU_DEC: res = sum_dec[7:0];
            ALU_INC: res = sum_inc[7:0];
            ALU_IOR: res = B_IN | W_IN;
            ALU_AND: res = B_IN & W_IN;
            ALU_XOR: res = B_IN ^ W_IN;
            ALU_MOVB: res = B_IN;
            ALU_COM: res = ~B_IN;
            ALU_RR: begin
                res = {CARRY_IN, B_IN[7:1]};
                c_out = B_IN[0];
                aff = '{z: 1'b0, nibble_carry_flag: 1'b0, c: 1'b1};
            end
            ALU_RL: begin
                res = {B_IN[6:0], CARRY_IN};
                c_out = B_IN[7];
                aff = '{z: 1'b0, nibble_carry_flag: 1'b0, c: 1'b1};
            end
            ALU_SWAP: begin
                res = {B_IN[3:0], B_IN[7:4]};
                aff = '0;
            end
            default: aff = '0;
        endcase
    end

    assign RES.result = res;
    assign RES.flags.c = c_out;
    assign RES.flags.nibble_carry_flag = nib_out;
    assign RES.flags.z = (res == 8'h00);
    assign RES.affect = aff;
endmodule : hw_alu

//--- rtl/hw_core.sv
// harvard core datapath: fetch/execute pipeline, working register, core file registers
`include "hw_consts.svh"
module hw_core #(
    parameter int PC_W = `HW_PC_W_DEF,
    parameter logic [10:0] RESET_VEC = `HW_RESET_VEC
) (
    input wire logic CLOCK,
    input wire logic RST,
    output logic [PC_W-1:0] PROG_ADDR,
    input wire logic [`HW_INSTR_W-1:0] PROG_DATA,
    output logic [`HW_FILE_AW-1:0] FILE_RADDR,
    input wire logic [`HW_DATA_W-1:0] FILE_RDATA,
    output hw_pkg::hw_file_wr_type FILE_WR,
    output logic [`HW_DATA_W-1:0] W_VALUE,
    output logic [`HW_DATA_W-1:0] STATUS_VALUE
);
    import hw_pkg::*;

    if (PC_W < `HW_PC_W_MIN || PC_W > `HW_PC_W_MAX) begin : g_bad_pc
        $error("PC_W must select 512, 1K or 2K words");
    end

    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    logic [11:0] ir_r;
    logic valid_r;
    logic [4:0] faddr_r;
    logic [4:0] faddr_nxt;
    logic [7:0] w_r;
    logic [7:0] w_nxt;
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [7:0] fsr_r;
    logic [7:0] fsr_nxt;
    hw_file_wr_type wr_r;
    hw_file_wr_type wr_nxt;

    // execute-stage decode of the held word
    wire hw_class_type cls = hw_class_type'(ir_r[11:10]);
    wire is_file = valid_r && (cls == CLS_FILE);
    wire is_lit = valid_r && (cls == CLS_LIT);
    wire is_goto = valid_r && (cls == CLS_GOTO);
    wire dest_f = ir_r[5];
    wire [7:0] lit_k = ir_r[7:0];
    wire hw_alu_op_type file_op = hw_alu_op_type'(ir_r[9:6]);
    wire hw_alu_op_type lit_op = (ir_r[9:8] == 2'b00) ? ALU_MOVB :
                                 (ir_r[9:8] == 2'b01) ? ALU_IOR :
                                 (ir_r[9:8] == 2'b10) ? ALU_AND : ALU_XOR;
    wire hw_alu_op_type alu_op = is_lit ? lit_op : file_op;

    // core registers answer from inside; a write still pending is forwarded
    wire core_addr = (faddr_r == `HW_ADDR_PCL) || (faddr_r == `HW_ADDR_STATUS) ||
                     (faddr_r == `HW_ADDR_FSR) || (faddr_r == `HW_ADDR_INDIRECT);
    wire fwd_hit = wr_r.we && (wr_r.addr == faddr_r);
    wire [7:0] fval = (faddr_r == `HW_ADDR_INDIRECT) ? 8'h00 :
                      (faddr_r == `HW_ADDR_PCL) ? pc_r[7:0] :
                      (faddr_r == `HW_ADDR_STATUS) ? status_r :
                      (faddr_r == `HW_ADDR_FSR) ? fsr_r :
                      fwd_hit ? wr_r.data : FILE_RDATA;
    wire [7:0] operand_b = is_lit ? lit_k : fval;

    hw_alu_out_type alu;

    hw_alu u_alu (
        .OP(alu_op),
        .W_IN(w_r),
        .B_IN(operand_b),
        .CARRY_IN(status_r[`HW_BIT_C]),
        .RES(alu)
    );

    // destinations: literal ops and d=0 go to the accumulator, d=1 and MOVW (either d) to the file
    wire op_live = is_lit || (is_file && (file_op != ALU_NOP) && (file_op != ALU_RSVD));
    wire f_we = is_file && op_live && ((file_op == ALU_MOVW) || dest_f);
    wire w_we = is_lit || (op_live && !f_we);
    wire pcl_we = f_we && (faddr_r == `HW_ADDR_PCL);
    wire branch = is_goto || pcl_we;
    wire [PC_W-1:0] goto_target = PC_W'(ir_r[9:0]);
    wire [PC_W-1:0] pc_inc = pc_r + {{(PC_W-1){1'b0}}, 1'b1};
    wire [PC_W-1:0] pcl_target = {pc_r[PC_W-1:8], alu.result};

    assign pc_nxt = is_goto ? goto_target : pcl_we ? pcl_target : pc_inc;
    assign w_nxt = w_we ? alu.result : w_r;
    assign fsr_nxt = (f_we && (faddr_r == `HW_ADDR_FSR)) ? alu.result : fsr_r;

    // flag updates win over a plain write of the status register
    wire [7:0] status_base = (f_we && (faddr_r == `HW_ADDR_STATUS)) ? alu.result : status_r;
    wire fl_en = op_live;
    always_comb begin
        status_nxt = status_base;
        if (fl_en && alu.affect.c) begin
            status_nxt[`HW_BIT_C] = alu.flags.c;
        end
        if (fl_en && alu.affect.nibble_carry_flag) begin
            status_nxt[`HW_BIT_NIBBLE] = alu.flags.nibble_carry_flag;
        end
        if (fl_en && alu.affect.z) begin
            status_nxt[`HW_BIT_Z] = alu.flags.z;
        end
    end

    // a zero pointer names nothing, so indirect writes through it are dropped
    assign wr_nxt.we = f_we && !core_addr;
    assign wr_nxt.addr = faddr_r;
    assign wr_nxt.data = alu.result;

    // fetch-stage address resolution uses the pointer the current op leaves behind
    assign faddr_nxt = (PROG_DATA[4:0] == `HW_ADDR_INDIRECT) ? fsr_nxt[4:0] : PROG_DATA[4:0];

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pc_r <= RESET_VEC[PC_W-1:0];
            ir_r <= 12'h000;
            valid_r <= 1'b0;
            faddr_r <= 5'h00;
        end else begin
            pc_r <= pc_nxt;
            ir_r <= PROG_DATA;
            valid_r <= !branch;
            faddr_r <= faddr_nxt;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            w_r <= `HW_W_RST;
            status_r <= `HW_STATUS_RST;
            fsr_r <= `HW_FSR_RST;
            wr_r <= '0;
        end else begin
            w_r <= w_nxt;
            status_r <= status_nxt;
            fsr_r <= fsr_nxt;
            wr_r <= wr_nxt;
        end
    end

    assign PROG_ADDR = pc_r;
    assign FILE_RADDR = faddr_r;
    assign FILE_WR = wr_r;
    assign W_VALUE = w_r;
    assign STATUS_VALUE = status_r;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    // the release edge still shows reset values, so history checks skip it explicitly

    wire is_add = is_file && (file_op == ALU_ADD);
    wire is_sub = is_file && (file_op == ALU_SUB);
    wire [8:0] add_wide = {1'b0, fval} + {1'b0, w_r};

    sequence s_flow_change;
        valid_r && branch;
    endsequence
    sequence s_refill;
        !valid_r ##1 valid_r;
    endsequence

    property p_branch_two_cycles;
        s_flow_change |=> s_refill;
    endproperty
    a_branch_two_cycles: assert property (p_branch_two_cycles) else $error("flow change not two cycles");

    property p_single_cycle;
        (valid_r && !branch) |=> valid_r;
    endproperty
    a_single_cycle: assert property (p_single_cycle) else $error("bubble after plain instruction");

    property p_fetch_next;
        (!RST && !branch) |=> (PROG_ADDR == $past(PROG_ADDR) + 1'b1);
    endproperty
    a_fetch_next: assert property (p_fetch_next) else $error("fetch address did not advance");

    property p_goto_target;
        is_goto |=> (PROG_ADDR == $past(goto_target));
    endproperty
    a_goto_target: assert property (p_goto_target) else $error("jump went to wrong address");

    property p_fetch_word;
        (!RST && !branch) |=> (valid_r && ir_r == $past(PROG_DATA));
    endproperty
    a_fetch_word: assert property (p_fetch_word) else $error("fetched word not held for execute");

    property p_w_only_by_ops;
        ($changed(w_r) && !$past(RST)) |-> $past(w_we);
    endproperty
    a_w_only_by_ops: assert property (p_w_only_by_ops) else $error("accumulator changed without an op");

    property p_add_flags;
        is_add |=> (status_r[`HW_BIT_C] == $past(add_wide[8])) &&
            (w_r == ($past(dest_f) ? $past(w_r) : $past(add_wide[7:0])));
    endproperty
    a_add_flags: assert property (p_add_flags) else $error("add carry wrong");

    property p_sub_borrow;
        is_sub |=> status_r[`HW_BIT_C] == ($past(fval) >= $past(w_r));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("subtract borrow wrong");

    property p_zero_flag;
        (op_live && alu.affect.z) |=> status_r[`HW_BIT_Z] == ($past(alu.result) == 8'h00);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

    property p_file_write;
        (f_we && !core_addr) |=> FILE_WR.we && FILE_WR.addr == $past(faddr_r) && FILE_WR.data == $past(alu.result);
    endproperty
    a_file_write: assert property (p_file_write) else $error("file write not issued");

    // a write of the low program counter byte jumps within the current page
    property p_pcl_jump;
        pcl_we |=> (PROG_ADDR[7:0] == $past(alu.result)) &&
            (PROG_ADDR[PC_W-1:8] == $past(PROG_ADDR[PC_W-1:8]));
    endproperty
    a_pcl_jump: assert property (p_pcl_jump) else $error("computed jump went to wrong address");

    // the word fetched behind a flow change must leave no trace
    property p_bubble_silent;
        s_flow_change |=> ##1 ($stable(w_r) && $stable(status_r));
    endproperty
    a_bubble_silent: assert property (p_bubble_silent) else $error("dropped word had an effect");
endmodule : hw_core

//--- bench/hw_mem_model.sv
// program memory and data register file that face the harvard core
module hw_mem_model #(
    parameter int PC_W = 11
) (
    input wire logic CLOCK,
    input wire logic [PC_W-1:0] PROG_ADDR,
    output logic [11:0] PROG_DATA,
    input wire logic [4:0] FILE_RADDR,
    output logic [7:0] FILE_RDATA,
    input wire hw_pkg::hw_file_wr_type FILE_WR
);
    timeunit 1ns;
    timeprecision 1ps;
    import hw_pkg::*;
    // whole program space on chip, one 12-bit word per address
    logic [11:0] rom [2**PC_W];
    logic [7:0] ram [32];
    // combinational reads: the core samples both buses in the same cycle
    assign PROG_DATA = rom[PROG_ADDR];
    assign FILE_RDATA = ram[FILE_RADDR];
    // a write is applied at the edge where it is seen, so the next read sees it
    always @(posedge CLOCK) begin
        if (FILE_WR.we === 1'b1) begin
            ram[FILE_WR.addr] <= FILE_WR.data;
        end
    end
endmodule : hw_mem_model

//--- bench/harvard_alu_fetch_datapath_tb.sv
// self-checking bench of the harvard core datapath
module harvard_alu_fetch_datapath_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hw_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [10:0] prog_addr;
    logic [11:0] prog_data;
    logic [4:0] file_raddr;
    logic [7:0] file_rdata;
    hw_file_wr_type file_wr;
    logic [7:0] w_value;
    logic [7:0] status_value;
    int num_errors = 0;
    int n_compared = 0;

    hw_core #(.PC_W(11)) u_dut (.CLOCK(clock), .RST(rst), .PROG_ADDR(prog_addr), .PROG_DATA(prog_data),
        .FILE_RADDR(file_raddr), .FILE_RDATA(file_rdata), .FILE_WR(file_wr), .W_VALUE(w_value),
        .STATUS_VALUE(status_value));
    hw_mem_model #(.PC_W(11)) u_mem (.CLOCK(clock), .PROG_ADDR(prog_addr), .PROG_DATA(prog_data),
        .FILE_RADDR(file_raddr), .FILE_RDATA(file_rdata), .FILE_WR(file_wr));

    initial begin
        forever #5 clock = ~clock;
    end

    function automatic logic [11:0] fop(input logic [3:0] op, input logic d, input logic [4:0] f);
        return {2'b00, op, d, f};
    endfunction : fop

    function automatic logic [11:0] lit(input logic [1:0] s, input logic [7:0] k);
        return {2'b11, s, k};
    endfunction : lit

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // reset, load the program under reset, release; returns just after the n-th edge that follows the last reset edge
    task automatic boot(input logic [11:0] p[$], input int n);
        @(posedge clock);
        rst <= 1'b1;
        for (int i = 0; i < 2048; i++) begin
            u_mem.rom[i] = (i < p.size()) ? p[i] : 12'h000;
        end
        for (int i = 0; i < 32; i++) begin
            u_mem.ram[i] = 8'h00;
        end
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1;
        repeat (n) @(posedge clock);
        #1;
    endtask : boot

    // core registers must never show up on the file write bus
    always @(posedge clock) begin
        if (file_wr.we === 1'b1) begin
            chk({11'h000, file_wr.addr inside {5'h00, 5'h02, 5'h03, 5'h04}}, 12'h000);
        end
    end

    task automatic t_add();
        boot('{lit(2'b00, 8'h0f), fop(ALU_MOVW, 1'b1, 5'h10), lit(2'b00, 8'h01), fop(ALU_ADD, 1'b1, 5'h10)}, 8);
        chk(u_mem.ram[16], 12'h010);
        chk(status_value[2:0], 12'h002);
        chk(w_value, 12'h001);
    endtask : t_add

    // f minus w, result to w
    task automatic t_sub(input logic [7:0] f, input logic [7:0] w, input logic [7:0] r, input logic [2:0] fl);
        boot('{lit(2'b00, f), fop(ALU_MOVW, 1'b1, 5'h11), lit(2'b00, w), fop(ALU_SUB, 1'b0, 5'h11)}, 8);
        chk(w_value, r);
        chk(status_value[2:0], fl);
        chk(u_mem.ram[17], f);
    endtask : t_sub

    task automatic t_shift_logic();
        boot('{lit(2'b00, 8'h81), fop(ALU_MOVW, 1'b1, 5'h12), fop(ALU_RR, 1'b1, 5'h12), fop(ALU_RL, 1'b0, 5'h12),
            lit(2'b10, 8'h0f), lit(2'b01, 8'h80)}, 10);
        chk(u_mem.ram[18], 12'h040);
        chk(w_value, 12'h081);
        chk(status_value[2:0], 12'h000);
        boot('{lit(2'b00, 8'h81), lit(2'b11, 8'h81)}, 5);
        chk(w_value, 12'h000);
        chk(status_value[2:0], 12'h004);
    endtask : t_shift_logic

    // goto at address 1: the word at 2 is fetched then dropped, fetch resumes at 5
    task automatic t_goto();
        logic [11:0] exp [5];
        exp = '{12'h000, 12'h001, 12'h002, 12'h005, 12'h006};
        boot('{lit(2'b00, 8'h11), {2'b10, 10'h005}, lit(2'b00, 8'h22)}, 0);
        for (int i = 0; i < 5; i++) begin
            chk({1'b0, prog_addr}, exp[i]);
            @(posedge clock);
            #1;
        end
        repeat (3) @(posedge clock);
        #1;
        chk(w_value, 12'h011);
        // computed jump through the low program counter byte; word 2 must drop
        boot('{lit(2'b00, 8'h06), fop(ALU_MOVW, 1'b1, 5'h02), lit(2'b00, 8'h22), lit(2'b00, 8'h44), lit(2'b00, 8'h44),
            lit(2'b00, 8'h44), lit(2'b11, 8'h33)}, 8);
        chk(w_value, 12'h035);
    endtask : t_goto

    // unary and file-logic ops chained through forwarded and stored bytes
    task automatic t_unary();
        boot('{lit(2'b00, 8'hff), fop(ALU_MOVW, 1'b1, 5'h13), fop(ALU_INC, 1'b1, 5'h13), fop(ALU_DEC, 1'b1, 5'h13),
            fop(ALU_COM, 1'b0, 5'h13), lit(2'b00, 8'h3c), fop(ALU_MOVW, 1'b1, 5'h14), fop(ALU_SWAP, 1'b1, 5'h14),
            fop(ALU_XOR, 1'b0, 5'h14), fop(ALU_AND, 1'b1, 5'h14), fop(ALU_CLR, 1'b1, 5'h13),
            fop(ALU_MOVB, 1'b0, 5'h13), fop(ALU_IOR, 1'b0, 5'h14), fop(ALU_XOR, 1'b0, 5'h14)}, 16);
        chk(u_mem.ram[19], 12'h000);
        chk(u_mem.ram[20], 12'h0c3);
        chk(w_value, 12'h000);
        chk(status_value[2:0], 12'h004);
    endtask : t_unary

    task automatic t_core_regs();
        boot('{lit(2'b00, 8'h15), fop(ALU_MOVW, 1'b1, 5'h04), lit(2'b00, 8'h5a), fop(ALU_MOVW, 1'b1, 5'h00),
            lit(2'b00, 8'h05), fop(ALU_MOVW, 1'b1, 5'h03), fop(ALU_SWAP, 1'b0, 5'h00)}, 10);
        chk(u_mem.ram[21], 12'h05a);
        chk(status_value[2:0], 12'h005);
        chk(u_mem.ram[3], 12'h000);
        chk(w_value, 12'h0a5);
    endtask : t_core_regs

    task automatic tally_and_finish();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (12) @(posedge clock);
        t_add();
        t_sub(8'h01, 8'h02, 8'hff, 3'b000);
        t_sub(8'h05, 8'h05, 8'h00, 3'b111);
        t_sub(8'h10, 8'h01, 8'h0f, 3'b001);
        t_shift_logic();
        t_goto();
        t_unary();
        t_core_regs();
        tally_and_finish();
    end
endmodule : harvard_alu_fetch_datapath_tb
